// ===== design/pirqe_pkg.sv
/*
 * package for the peripheral interrupt enable and flag block:
 * register offsets, bit positions and reset values.
 * assumes a 32-bit apb slave with one register per aligned word.
 */
package pirqe_pkg;
    // =========================================================
    // register byte offsets
    localparam logic [7:0] OFS_ENABLE = 8'h00;
    localparam logic [7:0] OFS_FLAGS = 8'h04;
    localparam logic [7:0] OFS_CONTROL = 8'h08;
    localparam logic [7:0] OFS_CLEAR = 8'h0C;
    // =========================================================
    // bit positions, shared by enable and flag registers
    localparam int BIT_OVERFLOW = 0;
    localparam int BIT_PERIOD = 1;
    localparam int BIT_CAPCMP = 2;
    localparam int BIT_ADC = 6;
    // control register bits
    localparam int BIT_GATE = 6;
    localparam int BIT_GLOBAL = 7;
    // =========================================================
    // masks and reset values
    localparam logic [7:0] IMPL_MASK = 8'h47;
    localparam logic [7:0] CTRL_MASK = 8'hC0;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [31:0] RD_ZERO = 32'h00000000;
endpackage

// ===== design/pirqe_top.sv
/*
 * peripheral interrupt gating: four sticky flags, per-source enables,
 * a peripheral group gate and a global enable feeding one request.
 * assumes event inputs are one-cycle pulses from logic on pclk and an
 * apb master on the same clock.
 */
`timescale 1ns/1ps
module pirqe_top
    import pirqe_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic adc_done,
    input wire logic capcmp_event,
    input wire logic period_match,
    input wire logic timer_overflow,
    output logic irq_out
);
    // =========================================================
    // bus decode
    logic [7:0] peripheral_irq_enable_ff, nxt_peripheral_irq_enable;
    logic [7:0] peripheral_irq_flags_ff, nxt_peripheral_irq_flags;
    logic [7:0] irq_control_register_ff, nxt_irq_control_register;
    logic [7:0] event_vec;
    logic [31:0] nxt_prdata;
    logic [31:0] prdata_ff;
    logic ack_ff;
    logic nxt_ack;
    wire access = psel && penable;
    // writes land only at the edge where pready is high
    wire wr = access && pready && pwrite;
    // read data is loaded in the first access cycle, before pready
    wire rd = access && !pwrite && !ack_ff;
    wire hit_en = paddr == OFS_ENABLE;
    wire hit_fl = paddr == OFS_FLAGS;
    wire hit_ct = paddr == OFS_CONTROL;
    wire hit_cl = paddr == OFS_CLEAR;
    wire mapped = hit_en || hit_fl || hit_ct || hit_cl;

    // one wait state: prdata stays a flop yet stands at the ready edge,
    // trading a cycle per transfer for a glitch-free read bus
    assign nxt_ack = access && !ack_ff;
    assign pready = access && ack_ff;
    // unmapped addresses answer with pslverr in the ready cycle
    assign pslverr = pready && !mapped;
    assign prdata = prdata_ff;

    // =========================================================
    // helper: a vector with one position forced low
    function automatic logic [7:0] without_bit(logic [7:0] v, int idx);
        logic [7:0] r;
        r = v;
        r[idx] = 1'b0;
        return r;
    endfunction

    // =========================================================
    // event vector laid out like the flag register
    always_comb begin
        event_vec = RST_BYTE;
        event_vec[BIT_ADC] = adc_done;
        event_vec[BIT_CAPCMP] = capcmp_event;
        event_vec[BIT_PERIOD] = period_match;
        event_vec[BIT_OVERFLOW] = timer_overflow;
    end

    // unimplemented bits are masked on write so they stay zero
    assign nxt_peripheral_irq_enable = (wr && hit_en) ?
        (pwdata[7:0] & IMPL_MASK) : peripheral_irq_enable_ff;
    assign nxt_irq_control_register = (wr && hit_ct) ?
        (pwdata[7:0] & CTRL_MASK) : irq_control_register_ff;
    // set beats clear so an event on the clear cycle is kept
    assign nxt_peripheral_irq_flags =
        ((peripheral_irq_flags_ff &
          ~((wr && hit_cl) ? pwdata[7:0] : RST_BYTE)) | event_vec)
        & IMPL_MASK;
    assign nxt_prdata = !rd ? prdata_ff :
        hit_en ? {24'h000000, peripheral_irq_enable_ff} :
        hit_fl ? {24'h000000, peripheral_irq_flags_ff} :
        hit_ct ? {24'h000000, irq_control_register_ff} : RD_ZERO;

    // =========================================================
    // register state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            peripheral_irq_enable_ff <= RST_BYTE;
            peripheral_irq_flags_ff <= RST_BYTE;
            irq_control_register_ff <= RST_BYTE;
            prdata_ff <= RD_ZERO;
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= nxt_ack;
            peripheral_irq_enable_ff <= nxt_peripheral_irq_enable;
            peripheral_irq_flags_ff <= nxt_peripheral_irq_flags;
            irq_control_register_ff <= nxt_irq_control_register;
            prdata_ff <= nxt_prdata;
        end
    end

    // =========================================================
    // request gating; software should clear stale flags before enabling
    wire [7:0] pend = peripheral_irq_flags_ff & peripheral_irq_enable_ff;
    wire gate = irq_control_register_ff[BIT_GATE];
    wire glob = irq_control_register_ff[BIT_GLOBAL];
    assign irq_out = glob && gate && (|pend);

    // =========================================================
    // checks
    property p_gate_blocks;
        @(posedge pclk) disable iff (!presetn)
        !irq_control_register_ff[BIT_GATE] |-> !irq_out;
    endproperty
    a_gate_blocks: assert property (p_gate_blocks)
        else $error("request without group gate");

    property p_flag_sets;
        @(posedge pclk) disable iff (!presetn)
        adc_done |=> peripheral_irq_flags_ff[BIT_ADC];
    endproperty
    a_flag_sets: assert property (p_flag_sets)
        else $error("adc flag missed event");

    property p_unimpl_zero;
        @(posedge pclk) disable iff (!presetn)
        (peripheral_irq_enable_ff & ~IMPL_MASK) == RST_BYTE;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero)
        else $error("unimplemented enable bit set");

    property p_flag_sticky;
        @(posedge pclk) disable iff (!presetn)
        (peripheral_irq_flags_ff[BIT_CAPCMP] && !(wr && hit_cl))
        |=> peripheral_irq_flags_ff[BIT_CAPCMP];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("flag cleared without software");

    property p_adc_clear;
        @(posedge pclk) disable iff (!presetn)
        (!peripheral_irq_flags_ff[BIT_ADC] && !adc_done)
        |=> !peripheral_irq_flags_ff[BIT_ADC];
    endproperty
    a_adc_clear: assert property (p_adc_clear)
        else $error("adc flag set without event");

    property p_req;
        @(posedge pclk) disable iff (!presetn)
        (glob && gate && peripheral_irq_flags_ff[BIT_PERIOD]
         && peripheral_irq_enable_ff[BIT_PERIOD]) |-> irq_out;
    endproperty
    a_req: assert property (p_req)
        else $error("request missing");

    property p_ovf_mask;
        @(posedge pclk) disable iff (!presetn)
        (irq_out && !peripheral_irq_enable_ff[BIT_OVERFLOW])
        |-> |without_bit(pend, BIT_OVERFLOW);
    endproperty
    a_ovf_mask: assert property (p_ovf_mask)
        else $error("masked overflow raised request");

    property p_adc_mask;
        @(posedge pclk) disable iff (!presetn)
        (irq_out && !peripheral_irq_enable_ff[BIT_ADC])
        |-> |without_bit(pend, BIT_ADC);
    endproperty
    a_adc_mask: assert property (p_adc_mask)
        else $error("masked adc raised request");

    property p_capcmp_mask;
        @(posedge pclk) disable iff (!presetn)
        (irq_out && !peripheral_irq_enable_ff[BIT_CAPCMP])
        |-> |without_bit(pend, BIT_CAPCMP);
    endproperty
    a_capcmp_mask: assert property (p_capcmp_mask)
        else $error("masked capture compare raised request");

    property p_period_mask;
        @(posedge pclk) disable iff (!presetn)
        (irq_out && !peripheral_irq_enable_ff[BIT_PERIOD])
        |-> |without_bit(pend, BIT_PERIOD);
    endproperty
    a_period_mask: assert property (p_period_mask)
        else $error("masked period match raised request");

    // =========================================================
    // request checks per source, plus the global enable check
    property p_adc_req;
        @(posedge pclk) disable iff (!presetn)
        (glob && gate && peripheral_irq_flags_ff[BIT_ADC]
         && peripheral_irq_enable_ff[BIT_ADC]) |-> irq_out;
    endproperty
    a_adc_req: assert property (p_adc_req)
        else $error("adc request missing");

    property p_capcmp_req;
        @(posedge pclk) disable iff (!presetn)
        (glob && gate && peripheral_irq_flags_ff[BIT_CAPCMP]
         && peripheral_irq_enable_ff[BIT_CAPCMP]) |-> irq_out;
    endproperty
    a_capcmp_req: assert property (p_capcmp_req)
        else $error("capture compare request missing");

    property p_ovf_req;
        @(posedge pclk) disable iff (!presetn)
        (glob && gate && peripheral_irq_flags_ff[BIT_OVERFLOW]
         && peripheral_irq_enable_ff[BIT_OVERFLOW]) |-> irq_out;
    endproperty
    a_ovf_req: assert property (p_ovf_req)
        else $error("overflow request missing");

    property p_no_global;
        @(posedge pclk) disable iff (!presetn)
        !irq_control_register_ff[BIT_GLOBAL] |-> !irq_out;
    endproperty
    a_no_global: assert property (p_no_global)
        else $error("request without global enable");

    // =========================================================
    // flag checks; set must win even on a clear cycle
    property p_capcmp_sets;
        @(posedge pclk) disable iff (!presetn)
        capcmp_event |=> peripheral_irq_flags_ff[BIT_CAPCMP];
    endproperty
    a_capcmp_sets: assert property (p_capcmp_sets)
        else $error("capture compare flag missed event");

    property p_period_sets;
        @(posedge pclk) disable iff (!presetn)
        period_match |=> peripheral_irq_flags_ff[BIT_PERIOD];
    endproperty
    a_period_sets: assert property (p_period_sets)
        else $error("period flag missed event");

    property p_ovf_sets;
        @(posedge pclk) disable iff (!presetn)
        timer_overflow |=> peripheral_irq_flags_ff[BIT_OVERFLOW];
    endproperty
    a_ovf_sets: assert property (p_ovf_sets)
        else $error("overflow flag missed event");

    property p_ovf_sticky;
        @(posedge pclk) disable iff (!presetn)
        (peripheral_irq_flags_ff[BIT_OVERFLOW] && !(wr && hit_cl))
        |=> peripheral_irq_flags_ff[BIT_OVERFLOW];
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky)
        else $error("overflow flag cleared without software");

    property p_flags_unimpl;
        @(posedge pclk) disable iff (!presetn)
        (peripheral_irq_flags_ff & ~IMPL_MASK) == RST_BYTE;
    endproperty
    a_flags_unimpl: assert property (p_flags_unimpl)
        else $error("unimplemented flag bit set");

    // =========================================================
    // bus checks
    property p_ready_wait;
        @(posedge pclk) disable iff (!presetn)
        (access && !ack_ff) |-> !pready;
    endproperty
    a_ready_wait: assert property (p_ready_wait)
        else $error("ready without wait state");

    property p_rd_enable;
        @(posedge pclk) disable iff (!presetn)
        (pready && !pwrite && hit_en)
        |-> prdata == {24'h000000, peripheral_irq_enable_ff};
    endproperty
    a_rd_enable: assert property (p_rd_enable)
        else $error("enable read data not standing");

    property p_unmapped_ignored;
        @(posedge pclk) disable iff (!presetn)
        (wr && !mapped) |=> ($stable(peripheral_irq_enable_ff)
            && $stable(irq_control_register_ff));
    endproperty
    a_unmapped_ignored: assert property (p_unmapped_ignored)
        else $error("unmapped write changed a register");

    property p_ctrl_unimpl;
        @(posedge pclk) disable iff (!presetn)
        (irq_control_register_ff & ~CTRL_MASK) == RST_BYTE;
    endproperty
    a_ctrl_unimpl: assert property (p_ctrl_unimpl)
        else $error("unimplemented control bit set");

    property p_en_write;
        @(posedge pclk) disable iff (!presetn)
        (wr && hit_en) |=> peripheral_irq_enable_ff ==
            ($past(pwdata[7:0]) & IMPL_MASK);
    endproperty
    a_en_write: assert property (p_en_write)
        else $error("enable write not stored");
endmodule

// ===== bench/pirqe_periph.sv
/*
 * partner model: the peripherals that raise one-cycle event pulses.
 * assumes the bench requests events by non-blocking writes on pclk.
 */
`timescale 1ns/1ps
// ==========
// event source
module pirqe_periph (
    input wire logic pclk,
    input wire logic [3:0] req,
    output logic [3:0] ev_ff
);
    // registered so a pulse never overlaps the request edge
    always_ff @(posedge pclk) begin
        ev_ff <= req;
    end
endmodule

// ===== bench/peripheral_irq_enable_flags_tb.sv
/*
 * self-checking bench for the peripheral interrupt gating block.
 * assumes pready answers without a bound known here; watchdog cuts hangs.
 */
`timescale 1ns/1ps
// ==========
// bench top
module peripheral_irq_enable_flags_tb;
    import pirqe_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000, prdata, q;
    logic pready, pslverr, irq_out, e;
    logic [3:0] req = 4'h0, ev;
    int err_count = 0, n_compared = 0;
    // rows: enable, control, events {adc,capcmp,period,ovf}, irq
    logic [23:0] rows [9] = '{24'h47C011, 24'h01C011, 24'h02C021,
        24'h04C041, 24'h40C081, 24'h4780F0, 24'h4740F0, 24'h00C0F0,
        24'h06C010};
    always #5 pclk = ~pclk;
    pirqe_periph per (.pclk(pclk), .req(req), .ev_ff(ev));
    pirqe_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .adc_done(ev[3]), .capcmp_event(ev[2]),
        .period_match(ev[1]), .timer_overflow(ev[0]), .irq_out(irq_out));
    // ==========
    // shared tasks
    task automatic chk(string nm, logic [31:0] x, logic [31:0] g);
        n_compared++;
        if (g !== x) begin
            $display("BAD %s exp %h got %h", nm, x, g);
            err_count++;
        end
    endtask
    // request held until pready is seen high; data taken at that edge
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        e = pslverr;
        q = prdata;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic fire(logic [3:0] v);
        req <= v;
        @(posedge pclk);
        req <= 4'h0;
        repeat (2) @(posedge pclk);
    endtask
    task automatic end_of_test;
        $display("compared %0d bad %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ==========
    // watchdog: whole run is a few hundred cycles
    initial begin
        #20000;
        err_count++;
        end_of_test();
    end
    // ==========
    // main sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, OFS_ENABLE, 32'h0);
        chk("en_rst", 32'h00000000, q);
        apb(1, OFS_ENABLE, 32'hFFFFFFFF);
        apb(0, OFS_ENABLE, 32'h0);
        chk("en_rw", 32'h00000047, q);
        apb(1, 8'h10, 32'h0);
        chk("slverr", 32'h1, {31'h0, e});
        foreach (rows[i]) begin
            apb(1, OFS_CLEAR, 32'hFF);
            apb(1, OFS_ENABLE, {24'h0, rows[i][23:16]});
            apb(1, OFS_CONTROL, {24'h0, rows[i][15:8]});
            fire(rows[i][7:4]);
            chk("irq", {31'h0, rows[i][0]}, {31'h0, irq_out});
            apb(0, OFS_FLAGS, 32'h0);
            chk("flags", {25'h0, rows[i][7], 3'h0, rows[i][6:4]}, q);
        end
        apb(0, OFS_CONTROL, 32'h0);
        chk("ctl", 32'h000000C0, q);
        // flag is sticky until software clears it
        apb(1, OFS_CLEAR, 32'hFF);
        apb(1, OFS_ENABLE, 32'h40);
        fire(4'h8);
        repeat (4) @(posedge pclk);
        apb(0, OFS_FLAGS, 32'h0);
        chk("sticky", 32'h00000040, q);
        chk("irq_hold", 32'h1, {31'h0, irq_out});
        apb(1, OFS_CLEAR, 32'h40);
        chk("irq_clr", 32'h0, {31'h0, irq_out});
        // reset in mid-run returns enables to zero
        apb(1, OFS_ENABLE, 32'h47);
        presetn <= 0;
        @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, OFS_ENABLE, 32'h0);
        chk("en_rst2", 32'h00000000, q);
        chk("irq_rst", 32'h0, {31'h0, irq_out});
        end_of_test();
    end
endmodule
